// >>> acd_pkg.sv
// shared constants and types for the ata command decoder
package acd_pkg;

  // ==========================================
  // task-file offsets
  localparam logic [2:0] TF_DATA     = 3'h0;
  localparam logic [2:0] TF_FEATURE  = 3'h1;
  localparam logic [2:0] TF_ERROR    = 3'h1;
  localparam logic [2:0] TF_SECCNT   = 3'h2;
  localparam logic [2:0] TF_SECNUM   = 3'h4;
  localparam logic [2:0] TF_CYLLOW   = 3'h4;
  localparam logic [2:0] TF_CYLHIGH  = 3'h5;
  localparam logic [2:0] TF_DRVHEAD  = 3'h6;
  localparam logic [2:0] TF_COMMAND  = 3'h7;
  localparam logic [2:0] TF_STATUS   = 3'h7;

  // ==========================================
  // command codes
  localparam logic [7:0] CMD_CHKPWR_A = 8'he5;
  localparam logic [7:0] CMD_CHKPWR_B = 8'h98;
  localparam logic [7:0] CMD_DIAG     = 8'h90;
  localparam logic [7:0] CMD_ERASE    = 8'hc0;
  localparam logic [7:0] CMD_FLUSH    = 8'he7;
  localparam logic [7:0] CMD_FORMAT   = 8'h50;
  localparam logic [7:0] CMD_IDENT    = 8'hec;

  // ==========================================
  // field positions and values
  localparam int         DH_DRIVE     = 4;
  localparam int         DH_LBA       = 6;
  localparam logic [7:0] ERR_ABRT     = 8'h04;
  localparam logic [7:0] ERR_RESET    = 8'h01;
  localparam logic [7:0] DIAG_OK      = 8'h01;
  localparam logic [7:0] DIAG_UNIT0   = 8'h02;
  localparam logic [7:0] DIAG_SLAVE   = 8'h80;
  localparam logic [7:0] SC_STANDBY   = 8'h00;
  localparam logic [7:0] TF_RESET     = 8'h00;
  localparam logic [7:0] WORD_LAST    = 8'hff;

  // ==========================================
  // timing
  localparam int         CLK_PERIOD_NS = 5;
  localparam int         WAKE_NS       = 200;
  localparam int         WAKE_CYC      = WAKE_NS / CLK_PERIOD_NS;
  localparam logic [7:0] WAKE_CNT      = 8'(WAKE_CYC);
  localparam logic [4:0] DIAG_CNT      = 5'h10;

  // ==========================================
  // identify words
  localparam logic [15:0] ID_W0  = 16'h044a;
  localparam logic [15:0] ID_W5  = 16'h0200;
  localparam logic [15:0] ID_W20 = 16'h0002;
  localparam logic [15:0] ID_W47 = 16'h8001;
  localparam logic [15:0] ID_W49 = 16'h0b00;
  localparam logic [15:0] ID_W51 = 16'h0200;
  localparam logic [15:0] ID_W53 = 16'h0007;
  localparam logic [15:0] ID_W63 = 16'h0007;
  localparam logic [15:0] ID_W64 = 16'h0003;
  localparam logic [15:0] ID_W65 = 16'h0078;
  localparam logic [15:0] ID_W80 = 16'h007e;
  localparam logic [15:0] ID_W81 = 16'h0019;
  localparam logic [15:0] ID_W82 = 16'h706b;
  localparam logic [15:0] ID_W83 = 16'h400c;
  localparam logic [15:0] ID_W84 = 16'h4000;

  typedef enum logic [5:0] {
    S_IDLE  = 6'h01,
    S_EXEC  = 6'h02,
    S_DIAG  = 6'h04,
    S_MEDIA = 6'h08,
    S_DIN   = 6'h10,
    S_DOUT  = 6'h20
  } acd_state_e;

endpackage

// >>> acd_ident_rom.sv
// identify parameter words with registered read
`timescale 1ns/10ps
module acd_ident_rom
  import acd_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // read port
  input  wire logic [7:0]  wordAddr,
  output logic      [15:0] wordData
);

  // ==========================================
  // lookup
  logic [15:0] wordNext;

  always_comb
  begin
    case (wordAddr)
      8'd0:                  wordNext = ID_W0;
      8'd5:                  wordNext = ID_W5;
      8'd20:                 wordNext = ID_W20;
      8'd47:                 wordNext = ID_W47;
      8'd49:                 wordNext = ID_W49;
      8'd51:                 wordNext = ID_W51;
      8'd53:                 wordNext = ID_W53;
      8'd63:                 wordNext = ID_W63;
      8'd64:                 wordNext = ID_W64;
      8'd65, 8'd66, 8'd67, 8'd68:
                             wordNext = ID_W65;
      8'd80:                 wordNext = ID_W80;
      8'd81:                 wordNext = ID_W81;
      8'd82:                 wordNext = ID_W82;
      8'd83:                 wordNext = ID_W83;
      8'd84:                 wordNext = ID_W84;
      default:               wordNext = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      wordData <= 16'h0000;
    else
      wordData <= wordNext;
  end

  // ==========================================
  // checks
  a_word_47_default: assert property (@(posedge ref_clk) disable iff (rst)
    wordAddr == 8'd47 |=> wordData == 16'h8001)
    else $error("identify word 47 wrong");

  a_reserved_words_zero: assert property (@(posedge ref_clk) disable iff (rst)
    (wordAddr >= 8'd91 && wordAddr <= 8'd127) |=> wordData == 16'h0000)
    else $error("reserved identify word not zero");

endmodule // acd_ident_rom

// >>> acd_self_test.sv
// internal diagnostic sequencer
`timescale 1ns/10ps
module acd_self_test
  import acd_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // control
  input  wire logic       start,
  input  wire logic       isSlave,
  input  wire logic [3:0] unitFault,
  input  wire logic       slaveFail,
  output logic            done,
  output logic      [7:0] code
);

  // ==========================================
  // run counter and code
  logic [4:0] runCnt_reg;
  logic       running_reg;
  logic [7:0] unitCode;

  always_comb
  begin
    unitCode = DIAG_OK;
    for (int i = 3; i >= 0; i--)
      if (unitFault[i])
        unitCode = DIAG_UNIT0 + 8'(i);
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      runCnt_reg  <= 5'h00;
      running_reg <= 1'b0;
      done        <= 1'b0;
      code        <= 8'h00;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        running_reg <= 1'b1;
        runCnt_reg  <= DIAG_CNT;
      end
      else if (running_reg && runCnt_reg == 5'h00)
      begin
        running_reg <= 1'b0;
        done        <= 1'b1;
        code        <= (!isSlave && slaveFail) ? (unitCode | DIAG_SLAVE) : unitCode;
      end
      else if (running_reg)
        runCnt_reg <= runCnt_reg - 5'h01;
    end
  end

endmodule // acd_self_test

// >>> acd_ata_command_decoder.sv
// task-file command decoder and executor of a flash drive
`timescale 1ns/10ps
// Behaviour
// - marked parameter registers used, others ignored
// - drive-only commands use just drive bit
// - full drive/head use takes head too
// - lba from head, cyl high, low, sector
// - power check: busy, count 00h, interrupt
// - never enter idle; report standby state
// - diagnostics put code in error register
// - diagnostics ignore drive; master reports slave
// - pre-erase sectors, may report write fault
// - flush cache then release busy, interrupt
// - format track takes one sector, discards
// - identify returns one sector like read
// - reserved identify bits read zero
// - word 47 reports 8001h
module acd_ata_command_decoder
  import acd_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // task-file port
  input  wire logic [2:0]  tfAddr,
  input  wire logic        tfWrEn,
  input  wire logic        tfRdEn,
  input  wire logic [7:0]  tfWrData,
  output logic      [7:0]  tfRdData,
  // data port
  input  wire logic        dataWrEn,
  input  wire logic        dataRdEn,
  input  wire logic [15:0] dataWrData,
  output logic      [15:0] dataRdData,
  // host signalling
  output logic             intrq,
  output logic             idleModeOn,
  // strap and diagnostics
  input  wire logic        deviceIsSlave,
  input  wire logic [3:0]  unitFault,
  input  wire logic        slaveFail,
  // medium
  output logic             eraseReq,
  output logic             flushReq,
  output logic      [27:0] mediaLba,
  output logic      [7:0]  mediaCount,
  output logic             mediaLbaMode,
  input  wire logic        mediaDone,
  input  wire logic        mediaFault
);

  // ==========================================
  // state
  acd_state_e  stateReg;
  acd_state_e  stateNext;
  logic [7:0]  featureReg;
  logic [7:0]  secCntReg;
  logic [7:0]  secNumReg;
  logic [7:0]  cylLowReg;
  logic [7:0]  cylHighReg;
  logic [7:0]  drvHeadReg;
  logic [7:0]  errorReg;
  logic [7:0]  cmdReg;
  logic [7:0]  waitCntReg;
  logic [7:0]  wordCntReg;
  logic        bsyReg;
  logic        drqReg;
  logic        dfReg;
  logic        errBitReg;
  logic        intrqReg;
  logic        slaveStrapReg;
  logic        strapTakenReg;
  logic        diagStart;
  logic        diagDone;
  logic [7:0]  diagCode;
  logic [15:0] romWord;
  logic        cmdWrite;
  logic        cmdAccept;
  logic        driveMatch;
  logic        isChkPwr;
  logic        finish;
  logic        abortCmd;
  logic        lastRead;
  logic        lastWrite;
  logic [7:0]  statusByte;

  // ==========================================
  // decode
  assign cmdWrite   = tfWrEn && tfAddr == TF_COMMAND;
  assign driveMatch = drvHeadReg[DH_DRIVE] == slaveStrapReg;
  assign cmdAccept  = cmdWrite && !bsyReg && (driveMatch || tfWrData == CMD_DIAG);
  assign isChkPwr   = cmdReg == CMD_CHKPWR_A || cmdReg == CMD_CHKPWR_B;
  assign lastRead   = stateReg == S_DIN && dataRdEn && wordCntReg == WORD_LAST;
  assign lastWrite  = stateReg == S_DOUT && dataWrEn && wordCntReg == WORD_LAST;
  assign diagStart  = stateReg == S_EXEC && cmdReg == CMD_DIAG;
  assign abortCmd   = stateReg == S_EXEC && stateNext == S_IDLE && !isChkPwr;
  assign statusByte = {bsyReg, !bsyReg, dfReg, !bsyReg, drqReg, 2'b00, errBitReg};
  assign idleModeOn = 1'b0;
  assign intrq      = intrqReg;

  // ==========================================
  // strap capture after reset release
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      slaveStrapReg <= 1'b0;
      strapTakenReg <= 1'b0;
    end
    else if (!strapTakenReg)
    begin
      slaveStrapReg <= deviceIsSlave;
      strapTakenReg <= 1'b1;
    end
  end

  // ==========================================
  // sequencer
  always_comb
  begin
    stateNext = stateReg;
    finish    = 1'b0;
    case (stateReg)
      S_IDLE:
        if (cmdAccept)
          stateNext = S_EXEC;
      S_EXEC:
        case (cmdReg)
          CMD_CHKPWR_A, CMD_CHKPWR_B:
            if (waitCntReg == 8'h00)
            begin
              stateNext = S_IDLE;
              finish    = 1'b1;
            end
          CMD_DIAG:   stateNext = S_DIAG;
          CMD_ERASE:  stateNext = S_MEDIA;
          CMD_FLUSH:  stateNext = S_MEDIA;
          CMD_FORMAT: stateNext = S_DOUT;
          CMD_IDENT:  stateNext = S_DIN;
          default:
          begin
            stateNext = S_IDLE;
            finish    = 1'b1;
          end
        endcase
      S_DIAG:
        if (diagDone)
        begin
          stateNext = S_IDLE;
          finish    = 1'b1;
        end
      S_MEDIA:
        if (mediaDone)
        begin
          stateNext = S_IDLE;
          finish    = 1'b1;
        end
      S_DIN:
        if (lastRead)
        begin
          stateNext = S_IDLE;
          finish    = 1'b1;
        end
      S_DOUT:
        if (lastWrite)
        begin
          stateNext = S_IDLE;
          finish    = 1'b1;
        end
      default:
        stateNext = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      stateReg   <= S_IDLE;
      cmdReg     <= TF_RESET;
      waitCntReg <= 8'h00;
      wordCntReg <= 8'h00;
    end
    else
    begin
      stateReg <= stateNext;
      if (cmdAccept)
      begin
        cmdReg     <= tfWrData;
        waitCntReg <= WAKE_CNT;
        wordCntReg <= 8'h00;
      end
      else
      begin
        if (stateReg == S_EXEC && waitCntReg != 8'h00)
          waitCntReg <= waitCntReg - 8'h01;
        if ((stateReg == S_DIN && dataRdEn) || (stateReg == S_DOUT && dataWrEn))
          wordCntReg <= wordCntReg + 8'h01;
      end
    end
  end

  // ==========================================
  // task-file registers, frozen while busy
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      featureReg <= TF_RESET;
      secCntReg  <= TF_RESET;
      secNumReg  <= TF_RESET;
      cylLowReg  <= TF_RESET;
      cylHighReg <= TF_RESET;
      drvHeadReg <= TF_RESET;
    end
    else if (finish && isChkPwr && stateReg == S_EXEC)
      secCntReg <= SC_STANDBY;
    else if (tfWrEn && !bsyReg)
      case (tfAddr)
        TF_FEATURE: featureReg <= tfWrData;
        TF_SECCNT:  secCntReg  <= tfWrData;
        TF_SECNUM:
        begin
          secNumReg <= tfWrData;
          cylLowReg <= tfWrData;
        end
        TF_CYLHIGH: cylHighReg <= tfWrData;
        TF_DRVHEAD: drvHeadReg <= tfWrData;
        default:    ;
      endcase
  end

  // ==========================================
  // status and error
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      bsyReg    <= 1'b0;
      drqReg    <= 1'b0;
      dfReg     <= 1'b0;
      errBitReg <= 1'b0;
      errorReg  <= ERR_RESET;
    end
    else
    begin
      drqReg <= stateNext == S_DIN || stateNext == S_DOUT;
      if (cmdAccept)
      begin
        bsyReg    <= 1'b1;
        dfReg     <= 1'b0;
        errBitReg <= 1'b0;
        errorReg  <= 8'h00;
      end
      else if (finish)
      begin
        bsyReg <= 1'b0;
        if (abortCmd)
        begin
          errorReg  <= ERR_ABRT;
          errBitReg <= 1'b1;
        end
        else if (stateReg == S_DIAG)
          errorReg <= diagCode;
        else if (stateReg == S_MEDIA && mediaFault)
        begin
          dfReg     <= 1'b1;
          errBitReg <= 1'b1;
        end
      end
    end
  end

  // ==========================================
  // interrupt: completion beats a same-cycle status read
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      intrqReg <= 1'b0;
    else if (finish)
      intrqReg <= 1'b1;
    else if ((tfRdEn && tfAddr == TF_STATUS) || cmdWrite)
      intrqReg <= 1'b0;
  end

  // ==========================================
  // medium requests
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      eraseReq     <= 1'b0;
      flushReq     <= 1'b0;
      mediaLba     <= 28'h0000000;
      mediaCount   <= 8'h00;
      mediaLbaMode <= 1'b0;
    end
    else
    begin
      eraseReq <= stateReg == S_EXEC && cmdReg == CMD_ERASE;
      flushReq <= stateReg == S_EXEC && cmdReg == CMD_FLUSH;
      if (stateReg == S_EXEC && cmdReg == CMD_ERASE)
      begin
        mediaLba     <= {drvHeadReg[3:0], cylHighReg, cylLowReg, secNumReg};
        mediaCount   <= secCntReg;
        mediaLbaMode <= drvHeadReg[DH_LBA];
      end
    end
  end

  // ==========================================
  // read answers
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      tfRdData   <= 8'h00;
      dataRdData <= 16'h0000;
    end
    else
    begin
      if (tfRdEn)
        case (tfAddr)
          TF_ERROR:   tfRdData <= errorReg;
          TF_SECCNT:  tfRdData <= secCntReg;
          TF_CYLLOW:  tfRdData <= cylLowReg;
          TF_CYLHIGH: tfRdData <= cylHighReg;
          TF_DRVHEAD: tfRdData <= drvHeadReg;
          TF_STATUS:  tfRdData <= statusByte;
          default:    tfRdData <= 8'h00;
        endcase
      if (stateReg == S_DIN && dataRdEn)
        dataRdData <= romWord;
    end
  end

  // ==========================================
  // helpers
  acd_ident_rom uRom (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .wordAddr (wordCntReg),
    .wordData (romWord)
  );

  acd_self_test uDiag (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .start     (diagStart),
    .isSlave   (slaveStrapReg),
    .unitFault (unitFault),
    .slaveFail (slaveFail),
    .done      (diagDone),
    .code      (diagCode)
  );

  // ==========================================
  // checks
  sequence accept_s;
    stateReg == S_IDLE && cmdAccept;
  endsequence

  sequence pwr_end_s;
    stateReg == S_EXEC && isChkPwr && waitCntReg == 8'h00;
  endsequence

  a_busy_on_accept: assert property (@(posedge ref_clk) disable iff (rst)
    accept_s |=> bsyReg && stateReg == S_EXEC)
    else $error("busy not raised on command");

  a_power_check_count: assert property (@(posedge ref_clk) disable iff (rst)
    pwr_end_s |=> secCntReg == 8'h00 && !bsyReg && intrqReg)
    else $error("power check result wrong");

  a_power_check_time: assert property (@(posedge ref_clk) disable iff (rst)
    accept_s ##1 isChkPwr |-> bsyReg [*8])
    else $error("power check released early");

  a_idle_never: assert property (@(posedge ref_clk) disable iff (rst)
    !idleModeOn)
    else $error("idle mode entered");

  a_diag_code_out: assert property (@(posedge ref_clk) disable iff (rst)
    stateReg == S_DIAG && diagDone |=> errorReg == $past(diagCode) && intrqReg)
    else $error("diagnostic code not reported");

  a_wrong_drive_ignored: assert property (@(posedge ref_clk) disable iff (rst)
    cmdWrite && !bsyReg && !driveMatch && tfWrData != CMD_DIAG |=> !bsyReg)
    else $error("other drive command taken");

  a_erase_fault_flag: assert property (@(posedge ref_clk) disable iff (rst)
    stateReg == S_MEDIA && mediaDone && mediaFault |=> dfReg && errBitReg && !bsyReg)
    else $error("write fault not reported");

  a_lba_packing: assert property (@(posedge ref_clk) disable iff (rst)
    eraseReq |-> mediaLba == {drvHeadReg[3:0], cylHighReg, cylLowReg, secNumReg})
    else $error("lba packing wrong");

  a_flush_release: assert property (@(posedge ref_clk) disable iff (rst)
    flushReq ##[1:1000] (mediaDone && stateReg == S_MEDIA) |=> !bsyReg && intrqReg)
    else $error("flush completion wrong");

  a_format_drain: assert property (@(posedge ref_clk) disable iff (rst)
    lastWrite |=> !drqReg && !bsyReg && intrqReg)
    else $error("format sector not closed");

  a_abort_unknown: assert property (@(posedge ref_clk) disable iff (rst)
    abortCmd |=> errorReg == 8'h04 && errBitReg && intrqReg)
    else $error("unsupported command not aborted");

endmodule // acd_ata_command_decoder

// >>> acd_medium_model.sv
// medium model answering erase and flush requests
`timescale 1ns/10ps
module acd_medium_model
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // requests and behaviour
  input  wire logic       eraseReq,
  input  wire logic       flushReq,
  input  wire logic [7:0] waitCyc,
  input  wire logic       faultOn,
  // answer
  output logic            mediaDone,
  output logic            mediaFault
);
  // ==========================================
  // completion counter
  logic [8:0] cntReg;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cntReg    <= 9'h000;
      mediaDone <= 1'b0;
    end
    else
    begin
      mediaDone <= (cntReg == 9'h001);
      if (eraseReq || flushReq)
        cntReg <= 9'(waitCyc) + 9'h001;
      else if (cntReg != 9'h000)
        cntReg <= cntReg - 9'h001;
    end
  end

  // fault flag means nothing outside the done pulse
  assign mediaFault = mediaDone ? faultOn : ~faultOn;
endmodule // acd_medium_model

// >>> ata_command_decoder_test.sv
// self-checking bench for the ata command decoder
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module ata_command_decoder_test;
  import acd_pkg::*;
  // ==========================================
  // signals
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  tfAddr = 3'h0;
  logic        tfWrEn = 1'b0;
  logic        tfRdEn = 1'b0;
  logic [7:0]  tfWrData = 8'h00;
  logic [7:0]  tfRdData;
  logic        dataWrEn = 1'b0;
  logic        dataRdEn = 1'b0;
  logic [15:0] dataWrData = 16'h0000;
  logic [15:0] dataRdData;
  logic        intrq, idleModeOn, eraseReq, flushReq, mediaLbaMode, mediaDone, mediaFault;
  logic        deviceIsSlave = 1'b0;
  logic [3:0]  unitFault = 4'h0;
  logic        slaveFail = 1'b0;
  logic [27:0] mediaLba;
  logic [7:0]  mediaCount, s;
  logic [7:0]  waitCyc = 8'h00;
  logic        faultOn = 1'b0;
  logic [15:0] w;
  int          n_fail = 0;
  int          checked = 0;
  logic [12:0] diagTab [4] = '{13'h0001, 13'h0102, 13'h0805, 13'h1484};

  always #2.5 ref_clk = ~ref_clk;

  acd_ata_command_decoder u_dut (.ref_clk(ref_clk), .rst(rst), .tfAddr(tfAddr),
    .tfWrEn(tfWrEn), .tfRdEn(tfRdEn), .tfWrData(tfWrData), .tfRdData(tfRdData),
    .dataWrEn(dataWrEn), .dataRdEn(dataRdEn), .dataWrData(dataWrData),
    .dataRdData(dataRdData), .intrq(intrq), .idleModeOn(idleModeOn),
    .deviceIsSlave(deviceIsSlave), .unitFault(unitFault), .slaveFail(slaveFail),
    .eraseReq(eraseReq), .flushReq(flushReq), .mediaLba(mediaLba),
    .mediaCount(mediaCount), .mediaLbaMode(mediaLbaMode), .mediaDone(mediaDone),
    .mediaFault(mediaFault));

  acd_medium_model u_med (.ref_clk(ref_clk), .rst(rst), .eraseReq(eraseReq),
    .flushReq(flushReq), .waitCyc(waitCyc), .faultOn(faultOn),
    .mediaDone(mediaDone), .mediaFault(mediaFault));

  // ==========================================
  // access tasks
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    tfAddr   <= a;
    tfWrData <= d;
    tfWrEn   <= 1'b1;
    @(posedge ref_clk);
    tfWrEn   <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    tfAddr <= a;
    tfRdEn <= 1'b1;
    @(posedge ref_clk);
    tfRdEn <= 1'b0;
    #1 d = tfRdData;
  endtask

  task automatic drd(output logic [15:0] d);
    @(posedge ref_clk);
    dataRdEn <= 1'b1;
    @(posedge ref_clk);
    dataRdEn <= 1'b0;
    #1 d = dataRdData;
  endtask

  task automatic dwr(input logic [15:0] d);
    @(posedge ref_clk);
    dataWrData <= d;
    dataWrEn   <= 1'b1;
    @(posedge ref_clk);
    dataWrEn   <= 1'b0;
  endtask

  // host waits for the interrupt before reading results
  task automatic waitIrq(input string nm);
    int k;
    @(posedge ref_clk) #1;
    for (k = 0; k < 600 && intrq !== 1'b1; k++)
      @(posedge ref_clk) #1;
    `CHK(nm, 1'b1, intrq)
  endtask

  task automatic waitDrq();
    int k;
    for (k = 0; k < 20; k++)
    begin
      rd(TF_STATUS, s);
      if (s[3] === 1'b1)
        break;
    end
    `CHK("drq", 1'b1, s[3])
  endtask

  task automatic waitReq(ref logic r);
    int k;
    for (k = 0; k < 20 && r !== 1'b1; k++)
      @(posedge ref_clk) #1;
  endtask

  task automatic endTest(input string nm);
    $display("test %s done, failures so far %0d", nm, n_fail);
  endtask

  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ==========================================
  // watchdog
  initial
  begin
    repeat (30000) @(posedge ref_clk);
    n_fail++;
    end_sim();
  end

  // ==========================================
  // tests
  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rd(TF_ERROR, s);
    `CHK("error reset", 8'h01, s)
    rd(TF_STATUS, s);
    `CHK("status reset", 8'h50, s)
    endTest("reset");
    // power check, both codes; parameters loaded before the code
    for (int i = 0; i < 2; i++)
    begin
      wr(TF_SECCNT, 8'h7f);
      wr(TF_COMMAND, i ? CMD_CHKPWR_B : CMD_CHKPWR_A);
      rd(TF_STATUS, s);
      `CHK("power busy", 8'h80, s)
      waitIrq("power intrq");
      rd(TF_SECCNT, s);
      `CHK("power count", SC_STANDBY, s)
      `CHK("idle mode", 1'b0, idleModeOn)
    end
    endTest("power");
    // diagnostics with the drive bit pointing at the other device
    wr(TF_DRVHEAD, 8'h10);
    foreach (diagTab[i])
    begin
      unitFault <= diagTab[i][11:8];
      slaveFail <= diagTab[i][12];
      wr(TF_COMMAND, CMD_DIAG);
      waitIrq("diag intrq");
      rd(TF_ERROR, s);
      `CHK("diag code", diagTab[i][7:0], s)
    end
    unitFault <= 4'h0;
    slaveFail <= 1'b0;
    endTest("diag");
    // command to the other drive is ignored
    wr(TF_COMMAND, CMD_FLUSH);
    repeat (4) @(posedge ref_clk);
    rd(TF_STATUS, s);
    `CHK("other drive status", 8'h50, s)
    `CHK("other drive intrq", 1'b0, intrq)
    endTest("drive select");
    // unsupported code
    wr(TF_DRVHEAD, 8'h00);
    wr(TF_COMMAND, 8'h27);
    waitIrq("abort intrq");
    rd(TF_ERROR, s);
    `CHK("abort error", ERR_ABRT, s)
    rd(TF_STATUS, s);
    `CHK("abort status", 8'h51, s)
    endTest("abort");
    // erase with lba fields, slow medium reporting a fault
    wr(TF_DRVHEAD, 8'h4a);
    wr(TF_CYLHIGH, 8'h12);
    wr(TF_CYLLOW, 8'h34);
    wr(TF_SECCNT, 8'h05);
    wr(TF_FEATURE, 8'hff);
    waitCyc <= 8'd30;
    faultOn <= 1'b1;
    wr(TF_COMMAND, CMD_ERASE);
    waitReq(eraseReq);
    `CHK("erase req", 1'b1, eraseReq)
    `CHK("erase lba", 28'ha123434, mediaLba)
    `CHK("erase count", 8'h05, mediaCount)
    `CHK("erase lba mode", 1'b1, mediaLbaMode)
    waitIrq("erase intrq");
    rd(TF_STATUS, s);
    `CHK("erase fault status", 8'h71, s)
    endTest("erase");
    // flush with prompt medium, head field set but ignored
    waitCyc <= 8'd0;
    faultOn <= 1'b0;
    wr(TF_DRVHEAD, 8'h0f);
    wr(TF_COMMAND, CMD_FLUSH);
    waitReq(flushReq);
    `CHK("flush req", 1'b1, flushReq)
    waitIrq("flush intrq");
    rd(TF_STATUS, s);
    `CHK("flush status", 8'h50, s)
    endTest("flush");
    // identify sector
    wr(TF_COMMAND, CMD_IDENT);
    waitDrq();
    for (int i = 0; i < 256; i++)
    begin
      drd(w);
      if (i == 0)
        `CHK("word 0", ID_W0, w)
      else if (i == 47)
        `CHK("word 47", ID_W47, w)
      else if (i inside {2, 4, 48, 50, 52, 62, 100, 255})
        `CHK("reserved word", 16'h0000, w)
    end
    waitIrq("ident intrq");
    rd(TF_STATUS, s);
    `CHK("ident status", 8'h50, s)
    endTest("identify");
    // format track sector is taken and dropped
    wr(TF_COMMAND, CMD_FORMAT);
    waitDrq();
    for (int i = 0; i < 256; i++)
      dwr(16'(i) ^ 16'h5a5a);
    waitIrq("format intrq");
    rd(TF_STATUS, s);
    `CHK("format status", 8'h50, s)
    endTest("format");
    end_sim();
  end
endmodule // ata_command_decoder_test
